// [shared/ppsc_cfg.svh]
`ifndef PPSC_CFG_SVH
`define PPSC_CFG_SVH

// ----------------------------------------------------------------
// Index offsets, one per register, within its index space
// ----------------------------------------------------------------
`define PPSC_OFF_PDN_CNTL      8'h07
`define PPSC_OFF_CFG_CNTL      8'h11
`define PPSC_OFF_REGA          8'h22
`define PPSC_OFF_REGB          8'h23
`define PPSC_OFF_REGC          8'h24
`define PPSC_OFF_LANEREV       8'h33
`define PPSC_OFF_DEEMPH_B      8'h34
`define PPSC_OFF_DEEMPH_CDE    8'h37
`define PPSC_OFF_REFCLK        8'h38
`define PPSC_OFF_DEEMPH_A      8'h39
`define PPSC_OFF_P_CNTL        8'h40
`define PPSC_OFF_LINK_CAPABILITY      8'h64
`define PPSC_OFF_MUX6          8'h66
`define PPSC_OFF_LINK_CONTROL     8'h68
`define PPSC_OFF_MUX8          8'h68
`define PPSC_OFF_LINK_CONTROL_SECOND    8'h88
`define PPSC_OFF_CLKGATE       8'h94
`define PPSC_OFF_SPEED         8'hA4
`define PPSC_OFF_STRAP_LC      8'hC0

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PPSC_B_L0S_EN          0
`define PPSC_F_L0S_IDLE        11:8
`define PPSC_F_GATE_LAT        3:0
`define PPSC_B_GATE_MAIN       0
`define PPSC_B_GATE_L0S        1
`define PPSC_B_GATE_SNDRCV     2
`define PPSC_B_PERM_STOP       3
`define PPSC_B_SND_PDN         5
`define PPSC_B_RCV_PDN         6
`define PPSC_B_LCORE_GDIS      16
`define PPSC_B_REFCLK_TX       26
`define PPSC_B_SBC_VALID_N     31
`define PPSC_F_SBC_LANEREV     7:4
`define PPSC_B_GPC_VALID_N     14
`define PPSC_B_GPC_REV_A       31
`define PPSC_B_GPC_REV_B       0
`define PPSC_F_SBC_DRV         6:5
`define PPSC_F_GPC_DRV         26:25
`define PPSC_B_GEN1_COMPL      13
`define PPSC_B_GEN2_EN         0
`define PPSC_F_TGT_SPEED       3:0
`define PPSC_B_GEN2_COMPL      4
`define PPSC_B_DEEMPH_HI       31
`define PPSC_B_GPC_DEEMPH_B    5
`define PPSC_F_SBC_DEEMPH_CDE  7:5

// ----------------------------------------------------------------
// Values, reset values and timing
// ----------------------------------------------------------------
`define PPSC_SPEED_GEN2        4'h2
`define PPSC_LINK_CAPABILITY_VAL      32'h0000_0402
`define PPSC_RST_ZERO          32'h0000_0000
`define PPSC_RST_REGA          32'h0000_0020
`define PPSC_RST_DEEMPH_HI     32'h8000_0000
`define PPSC_RST_DEEMPH_CDE    32'h0000_00E0
`define PPSC_MASK_16           32'h0000_FFFF
`define PPSC_MASK_32           32'hFFFF_FFFF
`define PPSC_INVALID_RD        32'hFFFF_FFFF
`define PPSC_DRV_BASE_MA       5'h12
`define PPSC_DRV_STEP_MA       5'h02
`define PPSC_CLK_PERIOD_NS     4
`define PPSC_L0S_TIME_NS       4000
`define PPSC_L0S_CODE_REF      8
`define PPSC_L0S_CYC           (`PPSC_L0S_TIME_NS / `PPSC_CLK_PERIOD_NS)
`define PPSC_L0S_STEP_CYC      (`PPSC_L0S_CYC / `PPSC_L0S_CODE_REF)

`endif

// [shared/ppsc_pkg.sv]
package ppsc_pkg;

  // Index space that a register access targets
  typedef enum logic [2:0] {
    SP_MISC = 3'h0, SP_CORE = 3'h1, SP_PORT = 3'h2,
    SP_CFG  = 3'h3, SP_CLK  = 3'h4
  } ppsc_space_e;

  // Storage slot of each writable register; SL_NONE marks no hit
  typedef enum logic [4:0] {
    SL_PDN, SL_CFG_CNTL, SL_REGA, SL_REGB, SL_REGC, SL_LANEREV,
    SL_DEEMPH_B, SL_DEEMPH_CDE, SL_REFCLK, SL_DEEMPH_A, SL_P_CNTL,
    SL_MUX6, SL_LINK_CONTROL, SL_MUX8, SL_LINK_CONTROL_SECOND, SL_CLKGATE,
    SL_SPEED, SL_STRAP_LC, SL_NONE
  } ppsc_slot_e;

  // Idle counter word
  typedef logic [11:0] ppsc_cnt_t;

  // Register access request
  typedef struct packed {
    logic        write;
    logic        read;
    ppsc_space_e space;
    logic [7:0]  index;
    logic [31:0] wdata;
  } ppsc_req_s;

  // Read answer
  typedef struct packed {
    logic        valid;
    logic [31:0] data;
  } ppsc_rsp_s;

  // Control outputs towards the cores
  typedef struct packed {
    logic       l0sEnable;
    logic       l0sEntry;
    logic [3:0] gatingLatency;
    logic       txMainGate;
    logic       txL0sGate;
    logic       txSndGate;
    logic       txRcvGate;
    logic       linkCoreClockGate;
    logic       txClockStopped;
    logic       refclkTxEnable;
    logic [1:0] gpcLaneReverse;
    logic [3:0] sbcLaneReverse;
    logic [1:0] gpcDeemphasis;
    logic [3:0] sbcDeemphasis;
    logic [4:0] gpcDriveMa;
    logic [4:0] sbcDriveMa;
    logic       forceGen1Compliance;
    logic       forceGen2Compliance;
    logic       gen2Capable;
    logic       targetGen2;
  } ppsc_ctrl_s;

endpackage

// [hw/ppsc_regbank.sv]
`timescale 1ns/1ps
`include "ppsc_cfg.svh"

// Summary of operation
// - Link control bit 0 enables L0s entry
// - Idle field code 8 gives 1000-clock timer
// - Gating latency field accepts 1100 binary
// - Power-down bits 2:0 gate three clock branches
// - Port power bit 5 allows send clock off
// - Port power bit 6 allows receive clock off
// - Clearing bit 16 enables link core gating
// - Permanent stop bit kills clock, core access
// - Bit 26 enables slot reference clock transmitter
// - South lane strap bits 7:4 reverse ports
// - General qualifier bit 14, reversal A/B bits
// - Two-bit code selects 18 to 24 mA
// - Strap bit 13 forces Gen1 compliance pattern
// - Speed control bit 0 enables Gen2 capability
// - Target speed 2 advertises Gen2
// - Bit 4 forces Gen2 compliance pattern
// - De-emphasis strap 1 means -3.5 dB
// - De-emphasis straps sit at fixed locations

module ppsc_regbank
(
  // Clock and reset
  input  wire logic                ref_clk,
  input  wire logic                rst,
  // Register access
  input  wire ppsc_pkg::ppsc_req_s req,
  output      ppsc_pkg::ppsc_rsp_s rsp,
  // Link activity from the core
  input  wire logic                linkIdle,
  // Controls towards the cores
  output      ppsc_pkg::ppsc_ctrl_s ctrl
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Maps a space and index to a storage slot
  function automatic ppsc_pkg::ppsc_slot_e decodeSlot
  (
    input ppsc_pkg::ppsc_space_e space,
    input logic [7:0]            index
  );
    ppsc_pkg::ppsc_slot_e s;
    s = ppsc_pkg::SL_NONE;
    case (space)
      ppsc_pkg::SP_MISC:
      begin
        case (index)
          `PPSC_OFF_PDN_CNTL:   s = ppsc_pkg::SL_PDN;
          `PPSC_OFF_REGA:       s = ppsc_pkg::SL_REGA;
          `PPSC_OFF_REGB:       s = ppsc_pkg::SL_REGB;
          `PPSC_OFF_REGC:       s = ppsc_pkg::SL_REGC;
          `PPSC_OFF_LANEREV:    s = ppsc_pkg::SL_LANEREV;
          `PPSC_OFF_DEEMPH_B:   s = ppsc_pkg::SL_DEEMPH_B;
          `PPSC_OFF_DEEMPH_CDE: s = ppsc_pkg::SL_DEEMPH_CDE;
          `PPSC_OFF_REFCLK:     s = ppsc_pkg::SL_REFCLK;
          `PPSC_OFF_DEEMPH_A:   s = ppsc_pkg::SL_DEEMPH_A;
          `PPSC_OFF_MUX6:       s = ppsc_pkg::SL_MUX6;
          `PPSC_OFF_MUX8:       s = ppsc_pkg::SL_MUX8;
          default:              s = ppsc_pkg::SL_NONE;
        endcase
      end
      ppsc_pkg::SP_CORE:
      begin
        case (index)
          `PPSC_OFF_CFG_CNTL:   s = ppsc_pkg::SL_CFG_CNTL;
          `PPSC_OFF_P_CNTL:     s = ppsc_pkg::SL_P_CNTL;
          default:              s = ppsc_pkg::SL_NONE;
        endcase
      end
      ppsc_pkg::SP_PORT:
      begin
        case (index)
          `PPSC_OFF_SPEED:      s = ppsc_pkg::SL_SPEED;
          `PPSC_OFF_STRAP_LC:   s = ppsc_pkg::SL_STRAP_LC;
          default:              s = ppsc_pkg::SL_NONE;
        endcase
      end
      ppsc_pkg::SP_CFG:
      begin
        case (index)
          `PPSC_OFF_LINK_CONTROL:  s = ppsc_pkg::SL_LINK_CONTROL;
          `PPSC_OFF_LINK_CONTROL_SECOND: s = ppsc_pkg::SL_LINK_CONTROL_SECOND;
          default:              s = ppsc_pkg::SL_NONE;
        endcase
      end
      ppsc_pkg::SP_CLK:
      begin
        if (index == `PPSC_OFF_CLKGATE)
          s = ppsc_pkg::SL_CLKGATE;
      end
      default: s = ppsc_pkg::SL_NONE;
    endcase
    return s;
  endfunction

  // Reset value of each slot; de-emphasis straps default to -3.5 dB
  function automatic logic [31:0] resetValue
  (
    input ppsc_pkg::ppsc_slot_e s
  );
    case (s)
      ppsc_pkg::SL_REGA:       return `PPSC_RST_REGA;
      ppsc_pkg::SL_DEEMPH_A:   return `PPSC_RST_DEEMPH_HI;
      ppsc_pkg::SL_DEEMPH_B:   return `PPSC_RST_DEEMPH_HI;
      ppsc_pkg::SL_DEEMPH_CDE: return `PPSC_RST_DEEMPH_CDE;
      default:                 return `PPSC_RST_ZERO;
    endcase
  endfunction

  // Implemented width of each slot; link controls are 16 bits
  function automatic logic [31:0] widthMask
  (
    input ppsc_pkg::ppsc_slot_e s
  );
    case (s)
      ppsc_pkg::SL_LINK_CONTROL:  return `PPSC_MASK_16;
      ppsc_pkg::SL_LINK_CONTROL_SECOND: return `PPSC_MASK_16;
      default:                 return `PPSC_MASK_32;
    endcase
  endfunction

  // Drive strength code to nominal milliamps
  function automatic logic [4:0] driveMa
  (
    input logic [1:0] code
  );
    return `PPSC_DRV_BASE_MA + `PPSC_DRV_STEP_MA * {3'h0, code};
  endfunction

  // Idle field code to timer length in clocks
  function automatic ppsc_pkg::ppsc_cnt_t idleLimit
  (
    input logic [3:0] code
  );
    return ppsc_pkg::ppsc_cnt_t'(code)
         * ppsc_pkg::ppsc_cnt_t'(`PPSC_L0S_STEP_CYC);
  endfunction

  // ----------------------------------------------------------------
  // Storage and state
  // ----------------------------------------------------------------
  logic [31:0]          regFile [ppsc_pkg::SL_NONE]; // Register words
  logic                 txStopped;        // Sticky clock stop
  logic                 gpcValidPrev;     // Last general qualifier
  logic                 sbcValidPrev;     // Last south qualifier
  logic [1:0]           gpcRevLat;        // Latched reversal A,B
  logic [1:0]           gpcDeLat;         // Latched de-emph A,B
  logic [3:0]           sbcRevLat;        // Latched reversal B..E
  logic [3:0]           sbcDeLat;         // Latched de-emph B..E
  ppsc_pkg::ppsc_cnt_t  idleCnt;          // Cycles of link idle
  ppsc_pkg::ppsc_rsp_s  next_rsp;         // Next read answer
  ppsc_pkg::ppsc_ctrl_s next_ctrl;        // Next control word

  // ----------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------
  wire ppsc_pkg::ppsc_slot_e reqSlot  = decodeSlot(req.space, req.index);
  wire logic                 slotHit  = reqSlot != ppsc_pkg::SL_NONE;
  // Core spaces go dead once the clock is stopped for good
  wire logic coreBlocked = txStopped
                         && req.space != ppsc_pkg::SP_MISC;
  wire logic capHit      = req.space == ppsc_pkg::SP_CFG
                         && req.index == `PPSC_OFF_LINK_CAPABILITY;
  wire logic wrTake      = req.write && slotHit && !coreBlocked;
  wire logic [31:0] wrWord = req.wdata & widthMask(reqSlot);

  // Field views of the stored words
  wire logic [31:0] pdnWord   = regFile[ppsc_pkg::SL_PDN];
  wire logic [31:0] pcWord    = regFile[ppsc_pkg::SL_P_CNTL];
  wire logic [31:0] lcWord    = regFile[ppsc_pkg::SL_LINK_CONTROL];
  wire logic [31:0] lc2Word   = regFile[ppsc_pkg::SL_LINK_CONTROL_SECOND];
  wire logic [31:0] regaWord  = regFile[ppsc_pkg::SL_REGA];
  wire logic [31:0] lrWord    = regFile[ppsc_pkg::SL_LANEREV];
  wire logic        gpcValidN = regaWord[`PPSC_B_GPC_VALID_N];
  wire logic        sbcValidN =
    regFile[ppsc_pkg::SL_MUX6][`PPSC_B_SBC_VALID_N];

  // Qualifier falling edge means straps are reasserted
  wire logic gpcCapture = gpcValidPrev && !gpcValidN;
  wire logic sbcCapture = sbcValidPrev && !sbcValidN;

  // Idle timer thresholds
  // Idle code of the link control word sets the L0s timer
  wire ppsc_pkg::ppsc_cnt_t l0sLimit =
    idleLimit(lcWord[`PPSC_F_L0S_IDLE]);
  wire logic [3:0] gateLat =
    regFile[ppsc_pkg::SL_CFG_CNTL][`PPSC_F_GATE_LAT];
  wire logic gateReady = idleCnt >= ppsc_pkg::ppsc_cnt_t'(gateLat);
  wire logic l0sOn     = lcWord[`PPSC_B_L0S_EN];
  wire logic l0sReady  = l0sOn && l0sLimit != '0
                       && idleCnt >= l0sLimit;

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  // Writes land in the addressed slot; blocked spaces are dropped
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < ppsc_pkg::SL_NONE; i++)
        regFile[i] <= resetValue(ppsc_pkg::ppsc_slot_e'(i));
    end
    else if (wrTake)
      regFile[reqSlot] <= wrWord;
  end

  // ----------------------------------------------------------------
  // Permanent clock stop
  // ----------------------------------------------------------------
  // Once set it stays until reset, even if the bit is cleared
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      txStopped <= 1'b0;
    else if (pdnWord[`PPSC_B_PERM_STOP])
      txStopped <= 1'b1;
  end

  // ----------------------------------------------------------------
  // Strap latches
  // ----------------------------------------------------------------
  // Straps follow the registers only on qualifier reassertion
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      gpcValidPrev <= 1'b0;
      sbcValidPrev <= 1'b0;
      gpcRevLat    <= 2'h0;
      sbcRevLat    <= 4'h0;
      gpcDeLat     <= 2'h3;
      sbcDeLat     <= 4'hF;
    end
    else
    begin
      gpcValidPrev <= gpcValidN;
      sbcValidPrev <= sbcValidN;
      // General core straps
      if (gpcCapture)
      begin
        gpcRevLat <= {regFile[ppsc_pkg::SL_REGB][`PPSC_B_GPC_REV_B],
                      regaWord[`PPSC_B_GPC_REV_A]};
        gpcDeLat  <= {regaWord[`PPSC_B_GPC_DEEMPH_B],
          regFile[ppsc_pkg::SL_DEEMPH_A][`PPSC_B_DEEMPH_HI]};
      end
      // South-side core straps
      if (sbcCapture)
      begin
        sbcRevLat <= lrWord[`PPSC_F_SBC_LANEREV];
        sbcDeLat  <=
          {regFile[ppsc_pkg::SL_DEEMPH_CDE][`PPSC_F_SBC_DEEMPH_CDE],
           regFile[ppsc_pkg::SL_DEEMPH_B][`PPSC_B_DEEMPH_HI]};
      end
    end
  end

  // ----------------------------------------------------------------
  // Idle counter
  // ----------------------------------------------------------------
  // Counts idle clocks, saturates, restarts on any activity
  always_ff @(posedge ref_clk)
  begin
    if (rst || !linkIdle)
      idleCnt <= '0;
    else if (idleCnt != '1)
      idleCnt <= idleCnt + ppsc_pkg::ppsc_cnt_t'(1);
  end

  // ----------------------------------------------------------------
  // Read answer
  // ----------------------------------------------------------------
  // Dead core spaces read all ones; unmapped reads give zero
  always_comb
  begin
    next_rsp.valid = req.read;
    next_rsp.data  = `PPSC_RST_ZERO;
    if (req.read)
    begin
      if (coreBlocked)
        next_rsp.data = `PPSC_INVALID_RD;
      else if (capHit)
        next_rsp.data = `PPSC_LINK_CAPABILITY_VAL;
      else if (slotHit)
        next_rsp.data = regFile[reqSlot] & widthMask(reqSlot);
    end
  end

  // Answer register
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      rsp <= '0;
    else
      rsp <= next_rsp;
  end

  // ----------------------------------------------------------------
  // Control word
  // ----------------------------------------------------------------
  // Transmit gating outputs drop while the clock is stopped for good
  always_comb
  begin
    next_ctrl = '0;
    next_ctrl.l0sEnable     = l0sOn;
    next_ctrl.l0sEntry      = l0sReady;
    next_ctrl.gatingLatency = gateLat;
    // Main, send and receive gating after the latency of idle clocks; L0s gating after the L0s timer
    next_ctrl.txMainGate = pdnWord[`PPSC_B_GATE_MAIN]
                         && gateReady;
    next_ctrl.txL0sGate  = pdnWord[`PPSC_B_GATE_L0S]
                         && l0sReady;
    next_ctrl.txSndGate  = pdnWord[`PPSC_B_GATE_SNDRCV]
                         && pcWord[`PPSC_B_SND_PDN]
                         && gateReady;
    next_ctrl.txRcvGate  = pdnWord[`PPSC_B_GATE_SNDRCV]
                         && pcWord[`PPSC_B_RCV_PDN]
                         && gateReady;
    next_ctrl.linkCoreClockGate =
      !regFile[ppsc_pkg::SL_CLKGATE][`PPSC_B_LCORE_GDIS];
    next_ctrl.txClockStopped = txStopped;
    next_ctrl.refclkTxEnable =
      regFile[ppsc_pkg::SL_REFCLK][`PPSC_B_REFCLK_TX];
    next_ctrl.gpcLaneReverse = gpcRevLat;
    next_ctrl.sbcLaneReverse = sbcRevLat;
    next_ctrl.gpcDeemphasis  = gpcDeLat;
    next_ctrl.sbcDeemphasis  = sbcDeLat;
    next_ctrl.gpcDriveMa =
      driveMa(regFile[ppsc_pkg::SL_REGC][`PPSC_F_GPC_DRV]);
    next_ctrl.sbcDriveMa =
      driveMa(regFile[ppsc_pkg::SL_MUX8][`PPSC_F_SBC_DRV]);
    next_ctrl.forceGen1Compliance =
      regFile[ppsc_pkg::SL_STRAP_LC][`PPSC_B_GEN1_COMPL];
    next_ctrl.gen2Capable =
      regFile[ppsc_pkg::SL_SPEED][`PPSC_B_GEN2_EN];
    next_ctrl.targetGen2 = next_ctrl.gen2Capable
      && lc2Word[`PPSC_F_TGT_SPEED] == `PPSC_SPEED_GEN2;
    next_ctrl.forceGen2Compliance =
      lc2Word[`PPSC_B_GEN2_COMPL];
    if (txStopped)
    begin
      // Stopped clock needs no gating requests
      next_ctrl.txMainGate = 1'b0;
      next_ctrl.txL0sGate  = 1'b0;
      next_ctrl.txSndGate  = 1'b0;
      next_ctrl.txRcvGate  = 1'b0;
    end
  end

  // Control register
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      ctrl <= '0;
    else
      ctrl <= next_ctrl;
  end

endmodule // ppsc_regbank

// [testbench/ppsc_endpoint_model.sv]
`timescale 1ns/1ps
// ----
// Endpoint side: link goes quiet a few clocks after traffic stops
// ----
module ppsc_endpoint_model
#(
  parameter int SETTLE = 3  // Clocks counted after quiet request; idle follows one clock later
)
(
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // Traffic control and link state
  input  wire logic idleReq,
  output logic      linkIdle = 1'b0
);
  logic [7:0] waitCnt = 8'h00;  // Clocks spent going quiet
  // Idle after the settle time; any traffic ends it at once
  always @(posedge ref_clk)
  begin
    if (rst || !idleReq)
    begin
      waitCnt  <= 8'h00;
      linkIdle <= 1'b0;
    end
    else if (waitCnt < 8'(SETTLE))
      waitCnt <= waitCnt + 8'h01;
    else
      linkIdle <= 1'b1;
  end
endmodule // ppsc_endpoint_model

// [testbench/ppsc_regbank_checker.sv]
`timescale 1ns/1ps
// ----
// Port checker for the register bank
// ----
module ppsc_regbank_checker
(
  // Clock, reset and access
  input wire logic                 ref_clk,
  input wire logic                 rst,
  input wire ppsc_pkg::ppsc_req_s  req,
  input wire ppsc_pkg::ppsc_rsp_s  rsp,
  // Link state and controls
  input wire logic                 linkIdle,
  input wire ppsc_pkg::ppsc_ctrl_s ctrl
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  // Write hits; core spaces only while the clock runs
  wire        wr   = req.write && !ctrl.txClockStopped;
  wire        wm   = req.write && req.space == ppsc_pkg::SP_MISC;
  wire        wc   = wr && req.space == ppsc_pkg::SP_CFG;
  wire [7:0]  ix   = req.index;
  wire [31:0] d    = req.wdata;
  wire        sArm = wm && ix == 8'h66 && !d[31];  // South qualifier on
  wire        gArm = wm && ix == 8'h22 && !d[14];  // General qualifier on
  logic [11:0] idleRun;   // Consecutive idle clocks
  logic [3:0]  lastCode;  // Idle timer code in force
  wire  [11:0] idleLim = 12'(lastCode) * 12'h07D;
  // Mirror of the idle count, saturating
  always_ff @(posedge ref_clk)
  begin
    if (rst || !linkIdle)
      idleRun <= 12'h000;
    else if (idleRun != 12'hFFF)
      idleRun <= idleRun + 12'h001;
  end
  // Idle code taken from link control writes
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      lastCode <= 4'h0;
    else if (wc && ix == 8'h68)
      lastCode <= d[11:8];
  end
  l0s_enable_a: assert property (wc && ix == 8'h68 |=> ##1
    ctrl.l0sEnable == $past(d[0], 2)) else $error("l0s enable");
  l0s_entry_a: assert property (ctrl.l0sEnable && idleRun >= idleLim
    && idleLim != 12'h000 && !ctrl.txClockStopped |=> ctrl.l0sEntry)
    else $error("l0s entry late");
  l0s_early_a: assert property ($rose(ctrl.l0sEntry) |->
    $past(idleRun) >= idleLim && idleLim != 12'h000) else $error("l0s early");
  gate_latency_a: assert property (wr && ix == 8'h11 &&
    req.space == ppsc_pkg::SP_CORE |=> ##1 ctrl.gatingLatency == $past(d[3:0], 2))
    else $error("gating latency");
  lcore_gate_a: assert property (wr && ix == 8'h94 &&
    req.space == ppsc_pkg::SP_CLK |=> ##1 ctrl.linkCoreClockGate != $past(d[16], 2))
    else $error("link core gate");
  refclk_tx_a: assert property (wm && ix == 8'h38 |=> ##1
    ctrl.refclkTxEnable == $past(d[26], 2)) else $error("refclk transmitter");
  target_speed_a: assert property (wc && ix == 8'h88 && ctrl.gen2Capable
    |=> ##1 ctrl.targetGen2 == ($past(d[3:0], 2) == 4'h2)) else $error("target");
  gpc_drive_a: assert property (wm && ix == 8'h24 |=> ##1
    ctrl.gpcDriveMa == 5'h12 + {$past(d[26:25], 2), 1'b0}) else $error("drive");
  stop_sticky_a: assert property (ctrl.txClockStopped |=>
    ctrl.txClockStopped) else $error("stop cleared");
  stop_gates_a: assert property (ctrl.txClockStopped |-> !(ctrl.txMainGate
    || ctrl.txL0sGate || ctrl.txSndGate || ctrl.txRcvGate)) else $error("gate");
  stop_read_a: assert property (ctrl.txClockStopped && req.read &&
    req.space != ppsc_pkg::SP_MISC |=> rsp.data == 32'hFFFF_FFFF)
    else $error("read after stop");
  sbc_hold_a: assert property ($changed(ctrl.sbcLaneReverse) |->
    $past(sArm, 3)) else $error("south strap moved");
  gpc_hold_a: assert property ($changed(ctrl.gpcLaneReverse) |->
    $past(gArm, 3)) else $error("general strap moved");
  cover property ($rose(ctrl.l0sEntry));
  cover property ($rose(ctrl.txClockStopped));
  cover property ($changed(ctrl.sbcLaneReverse));
endmodule // ppsc_regbank_checker

// Attach to every register bank
bind ppsc_regbank ppsc_regbank_checker u_chk (.ref_clk(ref_clk), .rst(rst),
  .req(req), .rsp(rsp), .linkIdle(linkIdle), .ctrl(ctrl));

// [testbench/testbench.sv]
`timescale 1ns/1ps
// ----
// Self-checking bench for the register bank
// ----
module testbench;
  localparam ppsc_pkg::ppsc_space_e MI = ppsc_pkg::SP_MISC;
  localparam ppsc_pkg::ppsc_space_e CO = ppsc_pkg::SP_CORE;
  localparam ppsc_pkg::ppsc_space_e PO = ppsc_pkg::SP_PORT;
  localparam ppsc_pkg::ppsc_space_e CF = ppsc_pkg::SP_CFG;
  localparam ppsc_pkg::ppsc_space_e CK = ppsc_pkg::SP_CLK;
  logic                  ref_clk = 1'b0;  // 250 MHz clock
  logic                  rst     = 1'b1;  // Synchronous reset
  logic                  idleReq = 1'b0;  // Ask the endpoint to go quiet
  logic                  linkIdle;        // Idle from the endpoint
  ppsc_pkg::ppsc_req_s   req     = '0;    // Access request
  ppsc_pkg::ppsc_rsp_s   rsp;             // Read answer
  ppsc_pkg::ppsc_ctrl_s  ctrl;            // Core controls
  ppsc_pkg::ppsc_space_e sp;              // Space of a table row
  int                    n_mismatch = 0;  // Failed checks
  int                    compares   = 0;  // Checks made
  int                    i;               // Loop index
  int                    n;               // Measured clocks
  // Space, index and value of each pattern write
  logic [42:0] tbl [11] = '{{MI, 8'h38, 32'h0400_0000},
    {CO, 8'h11, 32'h0000_000C}, {CO, 8'h40, 32'h0000_0060},
    {CK, 8'h94, 32'h0001_0000}, {CF, 8'h68, 32'hABCD_0801},
    {PO, 8'hA4, 32'h0000_0001}, {CF, 8'h88, 32'hFFFF_0012},
    {PO, 8'hC0, 32'h0000_2000}, {MI, 8'h24, 32'h0600_0000},
    {MI, 8'h68, 32'h0000_0040}, {MI, 8'h07, 32'h0000_0007}};
  always #2 ref_clk = ~ref_clk;
  ppsc_regbank u_dut (.ref_clk(ref_clk), .rst(rst), .req(req), .rsp(rsp),
    .linkIdle(linkIdle), .ctrl(ctrl));
  ppsc_endpoint_model u_ep (.ref_clk(ref_clk), .rst(rst), .idleReq(idleReq),
    .linkIdle(linkIdle));
  // Compare and count
  task automatic chk(input string nm, input logic [31:0] e, g);
    compares++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  // Counts, verdict, end of run
  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // One access held for one edge
  task automatic acc(input logic w, input ppsc_pkg::ppsc_space_e s,
    input logic [7:0] x, input logic [31:0] v);
    @(posedge ref_clk);
    req <= '{write: w, read: !w, space: s, index: x, wdata: v};
    @(posedge ref_clk);
    req <= '0;
  endtask
  task automatic wr(input ppsc_pkg::ppsc_space_e s, input logic [7:0] x,
    input logic [31:0] v);
    acc(1'b1, s, x, v);
  endtask
  // Read and compare the answer in its one valid cycle
  task automatic rd(input ppsc_pkg::ppsc_space_e s, input logic [7:0] x,
    input logic [31:0] e);
    acc(1'b0, s, x, 32'h0);
    #1;
    chk($sformatf("read %0d:%h", s, x), e, rsp.data);
    chk("valid", 32'h1, {31'h0, rsp.valid});
  endtask
  // Let a write reach the latched controls
  task automatic settle();
    repeat (3) @(posedge ref_clk);
    #1;
  endtask
  task automatic reset_dut();
    rst <= 1'b1;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
  endtask
  // Wait for L0s entry under a bound
  task automatic waitEntry();
    for (n = 0; ctrl.l0sEntry !== 1'b1; n++)
    begin
      if (n > 1200)
      begin
        n_mismatch++;
        conclude();
      end
      @(posedge ref_clk);
    end
  endtask
  // Main sequence
  initial
  begin
    reset_dut();
    rd(MI, 8'h22, 32'h0000_0020);
    rd(MI, 8'h39, 32'h8000_0000);
    rd(MI, 8'h37, 32'h0000_00E0);
    wr(CF, 8'h64, 32'h0);
    rd(CF, 8'h64, 32'h0000_0402);
    rd(MI, 8'hFF, 32'h0);
    chk("reset", 32'h1_297F, {ctrl.gpcDriveMa, ctrl.sbcDriveMa,
      ctrl.linkCoreClockGate, ctrl.gpcDeemphasis, ctrl.sbcDeemphasis});
    $display("test reset done");
    for (i = 0; i < 11; i++)
    begin
      sp = ppsc_pkg::ppsc_space_e'(tbl[i][42:40]);
      wr(sp, tbl[i][39:32], tbl[i][31:0]);
      rd(sp, tbl[i][39:32], sp == CF ? tbl[i][31:0] & 32'hFFFF : tbl[i][31:0]);
    end
    settle();
    chk("ctrl", 32'hE5_EF_16, {ctrl.l0sEnable, ctrl.gatingLatency,
      ctrl.refclkTxEnable, ctrl.linkCoreClockGate, ctrl.gen2Capable,
      ctrl.targetGen2, ctrl.forceGen1Compliance,
      ctrl.forceGen2Compliance, 3'h3, ctrl.gpcDriveMa, ctrl.sbcDriveMa});
    for (i = 0; i < 4; i++)
    begin
      wr(MI, 8'h24, 32'(i) << 25);
      wr(MI, 8'h68, 32'(i) << 5);
      settle();
      chk("drive", 32'h12_12 + 32'h202 * i, {ctrl.gpcDriveMa, 3'h0,
        ctrl.sbcDriveMa});
    end
    $display("test registers done");
    wr(MI, 8'h66, 32'h8000_0000);
    wr(MI, 8'h33, 32'h0000_00F0);
    wr(MI, 8'h34, 32'h0);
    wr(MI, 8'h37, 32'h0000_00A0);
    settle();
    chk("south hold", 32'h0F, {ctrl.sbcLaneReverse, ctrl.sbcDeemphasis});
    wr(MI, 8'h66, 32'h0);
    settle();
    chk("south", 32'hFA, {ctrl.sbcLaneReverse, ctrl.sbcDeemphasis});
    wr(MI, 8'h22, 32'h8000_4000);
    wr(MI, 8'h23, 32'h0000_0001);
    wr(MI, 8'h39, 32'h0);
    settle();
    chk("gen hold", 32'h3, {ctrl.gpcLaneReverse, ctrl.gpcDeemphasis});
    wr(MI, 8'h22, 32'h8000_0000);
    settle();
    chk("general", 32'hC, {ctrl.gpcLaneReverse, ctrl.gpcDeemphasis});
    $display("test straps done");
    @(posedge ref_clk);
    idleReq <= 1'b1;
    waitEntry();
    chk("l0s time", 32'h1, {31'h0, n >= 1000 && n <= 1010});
    settle();
    chk("gates", 32'hF, {ctrl.txMainGate, ctrl.txL0sGate,
      ctrl.txSndGate, ctrl.txRcvGate});
    wr(CO, 8'h40, 32'h0000_0020);
    wr(CK, 8'h94, 32'h0);
    settle();
    chk("gates", 32'h1E, {ctrl.linkCoreClockGate, ctrl.txMainGate,
      ctrl.txL0sGate, ctrl.txSndGate, ctrl.txRcvGate});
    idleReq <= 1'b0;
    wr(CF, 8'h68, 32'h0000_0800);
    idleReq <= 1'b1;
    repeat (1100) @(posedge ref_clk);
    #1;
    chk("l0s off", 32'h0, {31'h0, ctrl.l0sEntry});
    $display("test idle done");
    wr(MI, 8'h07, 32'h0000_000F);
    settle();
    chk("stop", 32'h10, {ctrl.txClockStopped, ctrl.txMainGate,
      ctrl.txL0sGate, ctrl.txSndGate, ctrl.txRcvGate});
    idleReq <= 1'b0;
    wr(MI, 8'h07, 32'h0);
    wr(CO, 8'h11, 32'h3);
    rd(CO, 8'h11, 32'hFFFF_FFFF);
    rd(CF, 8'h88, 32'hFFFF_FFFF);
    rd(MI, 8'h38, 32'h0400_0000);
    chk("latency", 32'hC, {28'h0, ctrl.gatingLatency});
    reset_dut();
    rd(CO, 8'h11, 32'h0);
    chk("restart", 32'h0, {31'h0, ctrl.txClockStopped});
    $display("test stop done");
    conclude();
  end
endmodule // testbench
